// >>> src/rtc_consts.svh
// offsets, field positions, reset values and timing counts of the rtc access block
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// ==========================================================================
// special-function bus offsets
`define RTC_SFR_ADR_OFS      8'hac
`define RTC_SFR_DAT_OFS      8'had

// ==========================================================================
// indirect addresses
`define RTC_IX_CAP_BANK      2'h0
`define RTC_IX_CTRL          4'h4
`define RTC_IX_ALM_BANK      2'h2

// ==========================================================================
// address/status register fields
`define RTC_ADR_BUSY         7
`define RTC_ADR_AUTO_READ_EN       6
`define RTC_ADR_SHORT        4
`define RTC_ADR_RST          8'h00
`define RTC_DAT_RST          8'h00

// ==========================================================================
// main control register fields
`define RTC_CTL_OSC_EN       7
`define RTC_CTL_MCLK_EN      6
`define RTC_CTL_FAIL         5
`define RTC_CTL_RUN          4
`define RTC_CTL_AEN          3
`define RTC_CTL_ALARM_FLAG_AUTORESET         2
`define RTC_CTL_LOAD         1
`define RTC_CTL_SNAP         0
`define RTC_CTL_RST          8'h00

// ==========================================================================
// timing
`define RTC_XFER_LONG        2'h2
`define RTC_XFER_SHORT       2'h1
`define RTC_CLK_PERIOD_NS    5
`define RTC_MISS_TIME_NS     100000
`define RTC_MISS_CYCLES      ((`RTC_MISS_TIME_NS + `RTC_CLK_PERIOD_NS - 1) / `RTC_CLK_PERIOD_NS)

`endif

// >>> src/rtc_pkg.sv
// types shared by the rtc access block
package rtc_pkg;

   // ==========================================================================
   // indirect transfer engine states
   typedef enum logic [1:0]
   {
      RTC_ST_IDLE = 2'b00,
      RTC_ST_RD   = 2'b01,
      RTC_ST_WR   = 2'b10
   } rtc_xfer_state_t;

endpackage

// >>> src/rtc_osc_mon.sv
// oscillator pin synchroniser, tick pulse and missing-clock detector
`timescale 1ns/10ps
`default_nettype none

module rtc_osc_mon #(
   parameter int MISS_CYCLES = 20000
) (
   input  wire logic clk,         // system clock
   input  wire logic rst_n,       // synchronous reset, active low
   input  wire logic osc_pin,     // raw timer oscillator
   input  wire logic det_en,      // detector enable
   output logic      tick,        // one pulse per oscillator cycle
   output logic      fail_pulse   // one pulse on timeout
);

   localparam int CW = $clog2(MISS_CYCLES + 1);

   logic          s1_q;
   logic          s2_q;
   logic          s3_q;
   logic [CW-1:0] cnt_q;
   logic          fired_q;

   wire           edge_seen = s2_q ^ s3_q;
   wire           timeout   = det_en & ~fired_q & (cnt_q == CW'(MISS_CYCLES));

   assign tick       = s2_q & ~s3_q;
   assign fail_pulse = timeout;

   // ==========================================================================
   // two-stage synchroniser and edge history
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end
      else
      begin
         s1_q <= osc_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // ==========================================================================
   // one-shot timeout on a stuck level
   always_ff @(posedge clk)
   begin
      if (!rst_n || !det_en || edge_seen)
      begin
         cnt_q   <= '0;
         fired_q <= 1'b0;
      end
      else
      begin
         if (cnt_q != CW'(MISS_CYCLES))
            cnt_q <= cnt_q + CW'(1);
         if (timeout)
            fired_q <= 1'b1;
      end
   end

endmodule // rtc_osc_mon

`default_nettype wire

// >>> src/rtc_timer_core.sv
// 32-bit timer with snapshot, load, alarm compare and auto reset
`timescale 1ns/10ps
`default_nettype none

module rtc_timer_core (
   input  wire logic        clk,          // system clock
   input  wire logic        rst_n,        // synchronous reset, active low
   input  wire logic        tick,         // oscillator cycle enable
   input  wire logic        run,          // timer counts
   input  wire logic        alarm_en,     // alarm compare enabled
   input  wire logic        auto_reset,   // clear timer after alarm
   input  wire logic        load_go,      // load timer from snapshot bytes
   input  wire logic        snap_go,      // copy timer into snapshot bytes
   input  wire logic        alarm_clr,    // control write clears flag
   input  wire logic        cap_wr,       // snapshot byte write
   input  wire logic        alm_wr,       // match byte write
   input  wire logic [1:0]  byte_sel,     // byte lane of the write
   input  wire logic [7:0]  wr_data,      // write byte
   output logic [31:0]      snapshot_bytes, // snapshot registers
   output logic [31:0]      match_bytes,  // alarm registers
   output logic             alarm_flag,   // alarm event flag
   output logic             load_done,    // load finished this cycle
   output logic             snap_done     // snapshot finished this cycle
);

   logic [31:0] timer_q;
   logic [31:0] cap_q;
   logic [31:0] alm_q;
   logic        flag_q;
   logic        arst_pend_q;

   wire         hit = tick & alarm_en & (timer_q == alm_q);

   assign snapshot_bytes = cap_q;
   assign match_bytes    = alm_q;
   assign alarm_flag     = flag_q;
   assign load_done      = tick & load_go;
   assign snap_done      = tick & snap_go;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         timer_q     <= 32'h0000_0000;
         cap_q       <= 32'h0000_0000;
         alm_q       <= 32'h0000_0000;
         flag_q      <= 1'b0;
         arst_pend_q <= 1'b0;
      end
      else
      begin
         if (tick)
         begin
            if (load_go)
               timer_q <= cap_q;
            else if (arst_pend_q)
               timer_q <= 32'h0000_0000;
            else if (run)
               timer_q <= timer_q + 32'h0000_0001;
            arst_pend_q <= hit & auto_reset;
         end
         // set wins over clear; flag lives one oscillator cycle
         flag_q <= hit | (flag_q & ~alarm_clr & ~tick);
         if (snap_done)
            cap_q <= timer_q;
         else if (cap_wr)
            cap_q[8*byte_sel +: 8] <= wr_data;
         if (alm_wr)
            alm_q[8*byte_sel +: 8] <= wr_data;
      end
   end

endmodule // rtc_timer_core

`default_nettype wire

// >>> src/rtc_indirect_access.sv
// rtc indirect access port, main control register, timer and oscillator monitor
`include "rtc_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module rtc_indirect_access #(
   parameter int MISS_CYCLES = `RTC_MISS_CYCLES
) (
   input  wire logic       clk,            // system clock, 200 MHz
   input  wire logic       rst_n,          // synchronous reset, active low
   input  wire logic [7:0] sfr_addr,       // special-function address
   input  wire logic       sfr_wr,         // write strobe, one cycle
   input  wire logic       sfr_rd,         // read strobe, one cycle
   input  wire logic [7:0] sfr_wdata,      // write data
   output logic      [7:0] sfr_rdata,      // read data, one cycle after sfr_rd
   input  wire logic       osc_pin,        // timer oscillator from pad
   output logic            osc_enable,     // oscillator and bias on
   output logic            osc_fail_flag,  // oscillator fail event
   output logic            alarm_event     // alarm event flag
);

   import rtc_pkg::*;

   // ==========================================================================
   // reset images of the two visible registers
   localparam logic [7:0] ADR_RST = `RTC_ADR_RST;
   localparam logic [7:0] CTL_RST = `RTC_CTL_RST;

   // ==========================================================================
   // state
   rtc_xfer_state_t state_q;
   logic [1:0]      cnt_q;
   logic [3:0]      addr_q;
   logic            auto_read_en_q;
   logic            short_q;
   logic [7:0]      data_q;
   logic [7:0]      rdata_q;
   logic            osc_en_q;
   logic            mclk_en_q;
   logic            fail_q;
   logic            run_q;
   logic            aen_q;
   logic            arst_q;
   logic            load_go_q;
   logic            snap_go_q;

   logic            tick_raw;
   logic            fail_pulse;
   logic [31:0]     snapshot_bytes;
   logic [31:0]     match_bytes;
   logic            alarm_flag;
   logic            load_done;
   logic            snap_done;

   // ==========================================================================
   // helpers
   function automatic logic is_bank(input logic [3:0] a);
      is_bank = (a[3:2] == `RTC_IX_CAP_BANK) || (a[3:2] == `RTC_IX_ALM_BANK);
   endfunction

   function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [1:0] s);
      pick_byte = w[8*s +: 8];
   endfunction

   // ==========================================================================
   // bus decode
   wire sel_adr  = (sfr_addr == `RTC_SFR_ADR_OFS);
   wire sel_dat  = (sfr_addr == `RTC_SFR_DAT_OFS);
   wire idle     = (state_q == RTC_ST_IDLE);
   wire wr_adr   = sfr_wr & sel_adr & idle;
   wire wr_dat   = sfr_wr & sel_dat & idle;
   wire rd_dat   = sfr_rd & sel_dat;

   // ==========================================================================
   // transfer starts
   // writes while busy are dropped, so the byte in flight stays intact
   wire busy_go   = wr_adr & sfr_wdata[`RTC_ADR_BUSY];
   wire auto_read_en_go = rd_dat & idle & auto_read_en_q;
   wire start_rd  = busy_go | auto_read_en_go;
   wire start_wr = wr_dat;
   wire [1:0] xfer_len = short_q ? `RTC_XFER_SHORT : `RTC_XFER_LONG;
   wire done     = ~idle & (cnt_q == 2'h1);
   wire int_wr   = done & (state_q == RTC_ST_WR);
   wire int_rd   = done & (state_q == RTC_ST_RD);

   // ==========================================================================
   // internal register selection
   wire sel_cap  = (addr_q[3:2] == `RTC_IX_CAP_BANK);
   wire sel_alm  = (addr_q[3:2] == `RTC_IX_ALM_BANK);
   wire sel_ctl  = (addr_q == `RTC_IX_CTRL);
   wire cap_wr   = int_wr & sel_cap;
   wire alm_wr   = int_wr & sel_alm;
   wire ctl_wr   = int_wr & sel_ctl;

   wire [7:0] ctl_rd = {osc_en_q, mclk_en_q, fail_q, run_q,
                        aen_q, alarm_flag, load_go_q, snap_go_q};
   wire [7:0] int_rd_byte = sel_cap ? pick_byte(snapshot_bytes, addr_q[1:0]) :
                            sel_alm ? pick_byte(match_bytes, addr_q[1:0]) :
                            sel_ctl ? ctl_rd : 8'h00;

   // ==========================================================================
   // read data image
   wire       st_busy = ~idle;
   wire       st_rsvd = 1'b0;
   wire       rd_adr  = sfr_rd & sel_adr;
   wire [7:0] adr_rd  = {st_busy, auto_read_en_q, st_rsvd, short_q, addr_q};
   wire [7:0] bus_rd  = rd_adr ? adr_rd :
                        rd_dat ? data_q : 8'h00;
   wire [7:0] rdata_d = sfr_rd ? bus_rd : 8'h00;

   // ==========================================================================
   // control write fields, taken from the data register at completion
   wire       cw_osc_en  = data_q[`RTC_CTL_OSC_EN];
   wire       cw_mclk_en = data_q[`RTC_CTL_MCLK_EN];
   wire       cw_fail    = data_q[`RTC_CTL_FAIL];
   wire       cw_run     = data_q[`RTC_CTL_RUN];
   wire       cw_aen     = data_q[`RTC_CTL_AEN];
   wire       cw_arst    = data_q[`RTC_CTL_ALARM_FLAG_AUTORESET];
   wire       cw_load    = data_q[`RTC_CTL_LOAD];
   wire       cw_snap    = data_q[`RTC_CTL_SNAP];

   // ==========================================================================
   // control next values
   // ticks only count while the oscillator is on; go bits wait for one
   wire       tick       = tick_raw & osc_en_q;
   wire       fail_clr   = ctl_wr & ~cw_fail;
   wire       fail_d     = fail_pulse | (fail_q & ~fail_clr);
   wire       load_go_set = ctl_wr & cw_load;
   wire       snap_go_set = ctl_wr & cw_snap;
   wire       load_go_d  = load_go_set | (load_go_q & ~load_done);
   wire       snap_go_d  = snap_go_set | (snap_go_q & ~snap_done);
   // address steps only inside the snapshot and match banks
   wire       in_bank    = is_bank(addr_q);
   wire [3:0] addr_inc   = in_bank ? addr_q + 4'h1 : addr_q;

   // ==========================================================================
   // transfer engine
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_q <= RTC_ST_IDLE;
         cnt_q   <= 2'h0;
      end
      else
      begin
         unique case (state_q)
            RTC_ST_IDLE:
            begin
               if (start_rd)
               begin
                  state_q <= RTC_ST_RD;
                  cnt_q   <= xfer_len;
               end
               else if (start_wr)
               begin
                  state_q <= RTC_ST_WR;
                  cnt_q   <= xfer_len;
               end
            end
            RTC_ST_RD, RTC_ST_WR:
            begin
               cnt_q <= cnt_q - 2'h1;
               if (done)
                  state_q <= RTC_ST_IDLE;
            end
            default:
               state_q <= RTC_ST_IDLE;
         endcase
      end
   end

   // ==========================================================================
   // address/status and data registers
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         addr_q         <= ADR_RST[3:0];
         auto_read_en_q <= ADR_RST[`RTC_ADR_AUTO_READ_EN];
         short_q        <= ADR_RST[`RTC_ADR_SHORT];
         data_q         <= `RTC_DAT_RST;
         rdata_q        <= 8'h00;
      end
      else
      begin
         rdata_q <= rdata_d;
         if (wr_adr)
         begin
            addr_q         <= sfr_wdata[3:0];
            auto_read_en_q <= sfr_wdata[`RTC_ADR_AUTO_READ_EN];
            short_q        <= sfr_wdata[`RTC_ADR_SHORT];
         end
         else if (done)
            addr_q <= addr_inc;
         if (wr_dat)
            data_q <= sfr_wdata;
         else if (int_rd)
            data_q <= int_rd_byte;
      end
   end

   // ==========================================================================
   // main control register
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         osc_en_q  <= CTL_RST[`RTC_CTL_OSC_EN];
         mclk_en_q <= CTL_RST[`RTC_CTL_MCLK_EN];
         fail_q    <= CTL_RST[`RTC_CTL_FAIL];
         run_q     <= CTL_RST[`RTC_CTL_RUN];
         aen_q     <= CTL_RST[`RTC_CTL_AEN];
         arst_q    <= CTL_RST[`RTC_CTL_ALARM_FLAG_AUTORESET];
         load_go_q <= CTL_RST[`RTC_CTL_LOAD];
         snap_go_q <= CTL_RST[`RTC_CTL_SNAP];
      end
      else
      begin
         if (ctl_wr)
         begin
            osc_en_q  <= cw_osc_en;
            mclk_en_q <= cw_mclk_en;
            run_q     <= cw_run;
            aen_q     <= cw_aen;
            arst_q    <= cw_arst;
         end
         fail_q    <= fail_d;
         load_go_q <= load_go_d;
         snap_go_q <= snap_go_d;
      end
   end

   // ==========================================================================
   // outputs
   assign sfr_rdata     = rdata_q;
   assign osc_enable    = osc_en_q;
   assign osc_fail_flag = fail_q;
   assign alarm_event   = alarm_flag;

   // ==========================================================================
   // oscillator monitor
   rtc_osc_mon #(
      .MISS_CYCLES (MISS_CYCLES)
   ) u_osc_mon (
      .clk        (clk),
      .rst_n      (rst_n),
      .osc_pin    (osc_pin),
      .det_en     (osc_en_q & mclk_en_q),
      .tick       (tick_raw),
      .fail_pulse (fail_pulse)
   );

   // ==========================================================================
   // timer, snapshot and alarm
   rtc_timer_core u_timer (
      .clk            (clk),
      .rst_n          (rst_n),
      .tick           (tick),
      .run            (run_q),
      .alarm_en       (aen_q),
      .auto_reset     (arst_q),
      .load_go        (load_go_q),
      .snap_go        (snap_go_q),
      .alarm_clr      (ctl_wr),
      .cap_wr         (cap_wr),
      .alm_wr         (alm_wr),
      .byte_sel       (addr_q[1:0]),
      .wr_data        (data_q),
      .snapshot_bytes (snapshot_bytes),
      .match_bytes    (match_bytes),
      .alarm_flag     (alarm_flag),
      .load_done      (load_done),
      .snap_done      (snap_done)
   );

endmodule // rtc_indirect_access

`default_nettype wire

// >>> testbench/rtc_ia_checker.sv
// port-level assertions for the rtc indirect access block
`include "rtc_consts.svh"
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// checker
module rtc_ia_checker #(
   parameter int MISS_CYCLES = 50
) (
   input wire logic       clk,           // system clock
   input wire logic       rst_n,         // sync reset, active low
   input wire logic [7:0] sfr_addr,      // bus address
   input wire logic       sfr_wr,        // write strobe
   input wire logic       sfr_rd,        // read strobe
   input wire logic [7:0] sfr_wdata,     // write data
   input wire logic [7:0] sfr_rdata,     // read data
   input wire logic       osc_pin,       // oscillator pin
   input wire logic       osc_enable,    // oscillator on
   input wire logic       osc_fail_flag, // fail flag
   input wire logic       alarm_event    // alarm flag
);
   import rtc_pkg::*;
   logic [31:0] stall_q;
   logic        pin_q;
   wire         adr_rd = sfr_rd && (sfr_addr == `RTC_SFR_ADR_OFS);
   wire         dat_rd = sfr_rd && (sfr_addr == `RTC_SFR_DAT_OFS);
   wire         adr_wr = sfr_wr && (sfr_addr == `RTC_SFR_ADR_OFS);
   wire         dat_wr = sfr_wr && (sfr_addr == `RTC_SFR_DAT_OFS);

   // cycles since the pin last moved
   always_ff @(posedge clk)
   begin
      stall_q <= (!rst_n || osc_pin != pin_q) ? 32'h0000_0000 : stall_q + 32'h0000_0001;
      pin_q   <= osc_pin;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence busy_go;  adr_wr && sfr_wdata[7]; endsequence
   sequence short_go; adr_wr && sfr_wdata[7] && sfr_wdata[4]; endsequence
   sequence poll;     adr_rd; endsequence

   rdata_idle_a: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
      else $error("read data not zero outside a read");
   unmapped_zero_a: assert property (sfr_rd && !adr_rd && !dat_rd |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   rsvd_bit_a: assert property (poll |=> !sfr_rdata[5])
      else $error("reserved address bit reads one");
   busy_start_a: assert property (busy_go ##1 poll |=> sfr_rdata[7])
      else $error("busy not set after read start");
   write_busy_a: assert property (dat_wr ##1 poll |=> sfr_rdata[7])
      else $error("busy not set after data write");
   short_done_a: assert property (short_go ##1 poll ##2 poll |=> !sfr_rdata[7])
      else $error("short transfer still busy");
   osc_src_a: assert property ($changed(osc_enable) |->
      $past(dat_wr, 1) || $past(dat_wr, 2) || $past(dat_wr, 3))
      else $error("oscillator enable moved without a write");
   fail_clear_a: assert property ($fell(osc_fail_flag) |->
      $past(dat_wr, 1) || $past(dat_wr, 2) || $past(dat_wr, 3))
      else $error("fail flag cleared without a write");
   fail_stall_a: assert property ($rose(osc_fail_flag) |-> stall_q >= MISS_CYCLES - 2)
      else $error("fail flag set while pin active");
   alarm_short_a: assert property (alarm_event && $rose(osc_pin) |-> ##[1:6] !alarm_event)
      else $error("alarm flag outlived one oscillator cycle");
endmodule // rtc_ia_checker

bind rtc_indirect_access rtc_ia_checker #(.MISS_CYCLES(MISS_CYCLES)) chk_i (.clk(clk),
   .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
   .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .osc_pin(osc_pin),
   .osc_enable(osc_enable), .osc_fail_flag(osc_fail_flag), .alarm_event(alarm_event));
`default_nettype wire

// >>> testbench/rtc_indirect_access_control_tb_top.sv
// self-checking bench for the rtc indirect access block
`include "rtc_consts.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
   $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end

// ==========================================================================
// bench top
module rtc_indirect_access_control_tb_top;
   import rtc_pkg::*;
   localparam int         MISS = 50;
   localparam logic [7:0] ADR  = `RTC_SFR_ADR_OFS;
   localparam logic [7:0] DAT  = `RTC_SFR_DAT_OFS;
   logic        clk, rst_n, sfr_wr, sfr_rd, osc_pin, rd_pend;
   logic        osc_enable, osc_fail_flag, alarm_event;
   logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, rd_v;
   logic [8:0]  note_q[$];
   logic [8:0]  note;
   logic [31:0] val;
   int          err_total, samples_checked, n, k;

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   rtc_indirect_access #(.MISS_CYCLES(MISS)) DUT (.clk(clk), .rst_n(rst_n),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .osc_pin(osc_pin), .osc_enable(osc_enable),
      .osc_fail_flag(osc_fail_flag), .alarm_event(alarm_event));

   // ==========================================================================
   // read data monitor
   always @(posedge clk) rd_pend <= sfr_rd;
   always @(negedge clk)
   begin
      if (rd_pend === 1'b1 && note_q.size() > 0)
      begin
         note = note_q.pop_front();
         if (note[8]) `CHK(sfr_rdata, note[7:0])
      end
   end

   // ==========================================================================
   // bus tasks
   task automatic final_report;
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic step;
      @(posedge clk);
      #1;
   endtask
   task automatic bw(input logic [7:0] a, input logic [7:0] d);
      step;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      step;
      sfr_wr = 1'b0;
   endtask
   task automatic br(input logic [7:0] a, input logic chk, input logic [7:0] e);
      sfr_addr = a;
      sfr_rd = 1'b1;
      step;
      sfr_rd = 1'b0;
      rd_v = sfr_rdata;
      note_q.push_back({chk, e});
      step;
   endtask
   task automatic wait_idle;
      n = 0;
      br(ADR, 1'b0, 8'h00);
      while (rd_v[7] !== 1'b0 && n < 20)
      begin
         br(ADR, 1'b0, 8'h00);
         n++;
      end
      if (n >= 20)
      begin
         err_total++;
         final_report;
      end
   endtask
   task automatic wdat(input logic [7:0] d);
      bw(DAT, d);
      wait_idle;
   endtask
   task automatic ir(input logic [7:0] a, input logic [7:0] e);
      bw(ADR, 8'h80 | a);
      wait_idle;
      br(DAT, 1'b1, e);
   endtask
   task automatic wr4(input logic [7:0] base, input logic [31:0] v);
      bw(ADR, base);
      for (int i = 0; i < 4; i++) wdat(v[8*i +: 8]);
   endtask
   task automatic rd4(input logic [31:0] e);
      bw(ADR, 8'hc0);
      wait_idle;
      for (int i = 0; i < 4; i++)
      begin
         br(DAT, 1'b1, e[8*i +: 8]);
         wait_idle;
      end
   endtask
   task automatic pulses(input int c);
      repeat (c)
      begin
         osc_pin = 1'b1;
         repeat (4) step;
         osc_pin = 1'b0;
         repeat (4) step;
      end
   endtask

   // ==========================================================================
   // main sequence
   initial
   begin
      {rst_n, sfr_wr, sfr_rd, osc_pin, sfr_addr, sfr_wdata} = '0;
      err_total = 0;
      samples_checked = 0;
      val = $urandom(32'h0000_49ed);
      repeat (20) @(posedge clk);
      #1;
      rst_n = 1'b1;
      br(ADR, 1'b1, 8'h00);
      br(DAT, 1'b1, 8'h00);
      br(8'h55, 1'b1, 8'h00);
      `CHK(osc_enable, 1'b0)
      $display("test reset values done");
      val = $urandom;
      wr4(8'h00, val);
      br(ADR, 1'b1, 8'h04);
      rd4(val);
      br(ADR, 1'b1, 8'h44);
      $display("test indirect bytes done");
      bw(ADR, 8'h04);
      wdat(8'h82);
      pulses(1);
      ir(8'h14, 8'h80);
      `CHK(osc_enable, 1'b1)
      k = $urandom_range(9, 2);
      bw(ADR, 8'h04);
      wdat(8'h90);
      pulses(k);
      wdat(8'h80);
      pulses(3);
      wdat(8'h81);
      pulses(1);
      ir(8'h04, 8'h80);
      rd4(val + k);
      $display("test load run snapshot done");
      wr4(8'h08, val + k + 2);
      br(ADR, 1'b1, 8'h0c);
      bw(ADR, 8'h04);
      wdat(8'h9c);
      ir(8'h04, 8'h98);
      n = 0;
      while (alarm_event !== 1'b1 && n < 80)
      begin
         osc_pin = n[2];
         step;
         n++;
      end
      if (n >= 80)
      begin
         err_total++;
         final_report;
      end
      `CHK(n inside {[12:32]}, 1'b1)
      osc_pin = 1'b0;
      repeat (4) step;
      pulses(1);
      `CHK(alarm_event, 1'b0)
      wdat(8'h81);
      pulses(1);
      rd4(32'h0000_0000);
      $display("test alarm done");
      `CHK(osc_fail_flag, 1'b0)
      wdat(8'hc0);
      repeat (MISS + 20) step;
      `CHK(osc_fail_flag, 1'b1)
      wdat(8'h80);
      `CHK(osc_fail_flag, 1'b0)
      $display("test oscillator fail done");
      final_report;
   end
endmodule // rtc_indirect_access_control_tb_top
`default_nettype wire
